// *** rtl/calu_pkg.sv ***
// Shared constants and types for the 16-bit arithmetic datapath.
// Assumes the instruction decoder drives opcodes from these enums.
package calu_pkg;

  localparam int DW = 16;

  // Status word bit positions and reset value
  localparam int SW_C  = 0;
  localparam int SW_Z  = 1;
  localparam int SW_OV = 2;
  localparam int SW_N  = 3;
  localparam int SW_DC = 8;
  localparam logic [15:0] SW_RESET = 16'h0000;

  // Divide: one step per divisor bit, then a final write step
  localparam logic [4:0] DIV_BITS = 5'h10;

  typedef enum logic [3:0] {
    OP_ADD = 4'b0000,
    OP_SUB = 4'b0001,
    OP_AND = 4'b0010,
    OP_IOR = 4'b0011,
    OP_XOR = 4'b0100,
    OP_MUL = 4'b0101,
    OP_SHL = 4'b0110,
    OP_SHA = 4'b0111
  } calu_op_t;

  typedef enum logic [2:0] {
    MUL_SS = 3'b000,
    MUL_UU = 3'b001,
    MUL_SU = 3'b010,
    MUL_US = 3'b011,
    MUL_SL = 3'b100,
    MUL_UL = 3'b101,
    MUL_BB = 3'b110
  } calu_mul_t;

  typedef enum logic [1:0] {
    DIV_IDLE = 2'b00,
    DIV_RUN  = 2'b01
  } calu_div_t;

endpackage

// *** rtl/calu_mul.sv ***
// 17x17 signed multiplier core with sign-mode operand extension.
// Purely combinational; the caller registers the product.
`timescale 1ns/1ps
module calu_mul
  import calu_pkg::*;
(
  input  wire logic [15:0] a,        // Multiplicand
  input  wire logic [15:0] b,        // Multiplier
  input  wire logic [4:0]  lit,      // Short unsigned literal
  input  wire calu_mul_t   mode,     // Sign mode
  output logic      [31:0] prod      // Product
);

  logic        a_sgn;
  logic        b_sgn;
  logic [16:0] a17;
  logic [16:0] b17;
  logic [33:0] p34;

  always_comb begin
    a_sgn = (mode == MUL_SS) || (mode == MUL_SU) || (mode == MUL_SL);
    b_sgn = (mode == MUL_SS) || (mode == MUL_US);
    // Extra top bit lets one signed array cover every sign mix
    a17   = {a_sgn & a[15], a};
    b17   = {b_sgn & b[15], b};
    if ((mode == MUL_SL) || (mode == MUL_UL)) begin
      b17 = {12'h000, lit};
    end else if (mode == MUL_BB) begin
      a17 = {9'h000, a[7:0]};
      b17 = {9'h000, b[7:0]};
    end
    // Widen both factors first so the product keeps all its bits
    p34  = $signed({{17{a17[16]}}, a17}) * $signed({{17{b17[16]}}, b17});
    prod = p34[31:0];
  end

endmodule // calu_mul

// *** rtl/calu_shift.sv ***
// Single-cycle bidirectional barrel shifter, signed amount.
// Amounts outside -16..16 are not expected from the decoder.
`timescale 1ns/1ps
module calu_shift (
  input  wire logic        [15:0] din,    // Operand
  input  wire logic signed [5:0]  amt,    // >0 right, <0 left
  input  wire logic               arith,  // Right shift keeps sign
  output logic             [15:0] dout    // Shifted result
);

  logic [5:0] mag;

  always_comb begin
    mag = amt[5] ? 6'(-amt) : 6'(amt);
    if (amt == 6'sd0) begin
      dout = din;
    end else if (amt[5]) begin
      dout = din << mag;
    end else if (arith) begin
      dout = 16'($signed(din) >>> mag);
    end else begin
      dout = din >> mag;
    end
  end

endmodule // calu_shift

// *** rtl/calu_core.sv ***
// Arithmetic datapath: add/sub/logic with flags, multiplier,
// stepped divider and barrel shifter. Operands come from the
// register array or memory read ports of the decoder, same clock.
`timescale 1ns/1ps

// Notes on behaviour
// - Datapath is sixteen bits; add, subtract, shift and logic ops.
// - Arithmetic operands and results are two's complement.
// - Add/subtract update carry, zero, negative, wrap, half carry; logic and shifts only zero, negative.
// - On subtract, carry and half carry mean no borrow.
// - Each operation except multiply and divide writes result and flags at byte or word width per size mode.
// - Operands from registers or memory; results to either.
// - Multiplier is a 17x17 array for all sign mixes.
// - Modes: SS, UU, SU, US, signed/unsigned by literal, byte UU.
// - Divider does 32/16 and 16/16, signed and unsigned.
// - Quotient goes to register zero, remainder to register one.
// - Any divisor register; any even-aligned dividend pair.
// - One step per divisor bit, same length for both sizes.
// - Divide stepped by a loop; pauses keep all state.
// - Shifter moves up to 16 bits, either way, one cycle.
// - Shifter operand from a register or memory.
// - Signed amount: positive shifts right, negative left.
// - Zero shift amount leaves the operand unchanged.
// - Half carry from bit 3 for bytes, bit 7 for words.
// - Signed wrap set when the sign bit wrongly changes.
module calu_core
  import calu_pkg::*;
(
  input  wire logic              clk,          // Instruction clock
  input  wire logic              rstn,         // Async reset, low
  input  wire logic              op_valid,     // Execute this cycle
  input  wire calu_op_t          op_code,      // Operation
  input  wire logic              byte_mode,    // Byte-width op
  input  wire logic              a_from_mem,   // A from memory
  input  wire logic              b_from_mem,   // B from memory
  input  wire logic       [15:0] reg_a,        // A register data
  input  wire logic       [15:0] mem_a,        // A memory data
  input  wire logic       [15:0] reg_b,        // B register data
  input  wire logic       [15:0] mem_b,        // B memory data
  input  wire logic       [4:0]  mul_lit,      // Multiply literal
  input  wire calu_mul_t         mul_mode,     // Multiply mode
  input  wire logic signed [5:0] shift_amt,    // Shift amount
  input  wire logic              dst_to_mem,   // Result to memory
  output logic            [15:0] res_data,     // Result low word
  output logic            [15:0] res_hi,       // Product high word
  output logic                   reg_we,       // Register write
  output logic                   mem_we,       // Memory write
  output logic            [15:0] status_word,  // Flags
  input  wire logic              div_step,     // One divide step
  input  wire logic              div_signed,   // Signed divide
  input  wire logic              div_long,     // 32-bit dividend
  input  wire logic       [3:0]  divisor_reg,  // Divisor index
  input  wire logic       [3:0]  dividend_low_reg, // Dividend index
  output logic            [3:0]  rd_dsr_addr,  // Divisor read addr
  output logic            [3:0]  rd_lo_addr,   // Dividend low addr
  output logic            [3:0]  rd_hi_addr,   // Dividend high addr
  input  wire logic       [15:0] rd_dsr_data,  // Divisor data
  input  wire logic       [15:0] rd_lo_data,   // Dividend low
  input  wire logic       [15:0] rd_hi_data,   // Dividend high
  output logic                   div_busy,     // Divide in progress
  output logic                   wreg0_we,     // Quotient write
  output logic            [15:0] wreg0_data,   // Quotient
  output logic                   wreg1_we,     // Remainder write
  output logic            [15:0] wreg1_data    // Remainder
);

  logic [15:0] opa;
  logic [15:0] opb;
  logic [15:0] opb_eff;
  logic        is_sub;
  logic [16:0] sum17;
  logic [8:0]  lo9;
  logic [4:0]  lo5;
  logic [15:0] alu_res;
  logic [15:0] res_w;
  logic [15:0] shf_res;
  logic [31:0] prod;
  logic        f_c;
  logic        f_dc;
  logic        f_ov;
  logic        f_n;
  logic        f_z;
  logic [15:0] next_status;

  // Operand source per addressing mode
  always_comb begin
    opa = a_from_mem ? mem_a : reg_a;
    opb = b_from_mem ? mem_b : reg_b;
  end

  calu_mul u_mul (
    .a    (opa),
    .b    (opb),
    .lit  (mul_lit),
    .mode (mul_mode),
    .prod (prod)
  );

  calu_shift u_shift (
    .din   (opa),
    .amt   (shift_amt),
    .arith (op_code == OP_SHA),
    .dout  (shf_res)
  );

  // Subtract is A + ~B + 1, so carries read as not-borrow
  always_comb begin
    is_sub  = (op_code == OP_SUB);
    opb_eff = is_sub ? ~opb : opb;
    sum17   = {1'b0, opa} + {1'b0, opb_eff} + 17'(is_sub);
    lo9     = {1'b0, opa[7:0]} + {1'b0, opb_eff[7:0]} + 9'(is_sub);
    lo5     = {1'b0, opa[3:0]} + {1'b0, opb_eff[3:0]} + 5'(is_sub);
  end

  always_comb begin
    case (op_code)
      OP_ADD:  alu_res = sum17[15:0];
      OP_SUB:  alu_res = sum17[15:0];
      OP_AND:  alu_res = opa & opb;
      OP_IOR:  alu_res = opa | opb;
      OP_XOR:  alu_res = opa ^ opb;
      OP_MUL:  alu_res = prod[15:0];
      OP_SHL:  alu_res = shf_res;
      OP_SHA:  alu_res = shf_res;
      default: alu_res = opa;
    endcase
    // Byte ops other than multiply pass the upper byte of operand A through
    if (byte_mode && (op_code != OP_MUL)) begin
      res_w = {opa[15:8], alu_res[7:0]};
    end else begin
      res_w = alu_res;
    end
  end

  // Flags follow the active width
  always_comb begin
    if (byte_mode) begin
      f_c  = lo9[8];
      f_dc = lo5[4];
      f_ov = (opa[7] == opb_eff[7]) && (res_w[7] != opa[7]);
      f_n  = res_w[7];
      f_z  = (res_w[7:0] == 8'h00);
    end else begin
      f_c  = sum17[16];
      f_dc = lo9[8];
      f_ov = (opa[15] == opb_eff[15]) && (res_w[15] != opa[15]);
      f_n  = res_w[15];
      f_z  = (res_w == 16'h0000);
    end
  end

  always_comb begin
    next_status = status_word;
    case (op_code)
      OP_ADD, OP_SUB: begin
        next_status[SW_C]  = f_c;
        next_status[SW_DC] = f_dc;
        next_status[SW_OV] = f_ov;
        next_status[SW_N]  = f_n;
        next_status[SW_Z]  = f_z;
      end
      OP_AND, OP_IOR, OP_XOR, OP_SHL, OP_SHA: begin
        next_status[SW_N] = f_n;
        next_status[SW_Z] = f_z;
      end
      default: next_status = status_word;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_word <= SW_RESET;
    end else if (op_valid) begin
      status_word <= next_status;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      res_data <= 16'h0000;
      res_hi   <= 16'h0000;
      reg_we   <= 1'b0;
      mem_we   <= 1'b0;
    end else begin
      reg_we <= op_valid && !dst_to_mem;
      mem_we <= op_valid && dst_to_mem;
      if (op_valid) begin
        res_data <= res_w;
        res_hi   <= prod[31:16];
      end
    end
  end

  // Divider: first step latches operands, 16 steps of restoring
  // division on magnitudes, last step signs and writes results.
  // Operands are latched so an interrupt handler that reuses the
  // registers between steps cannot corrupt the divide.
  calu_div_t   div_state;
  logic [4:0]  div_cnt;
  logic [16:0] div_rem;
  logic [15:0] div_q;
  logic [15:0] div_dsr;
  logic        neg_q;
  logic        neg_r;
  logic [31:0] dvd;
  logic [31:0] dvd_mag;
  logic [16:0] shl_rem;
  logic [17:0] trial;

  always_comb begin
    rd_dsr_addr = divisor_reg;
    rd_lo_addr  = {dividend_low_reg[3:1], 1'b0};
    rd_hi_addr  = {dividend_low_reg[3:1], 1'b1};
    if (div_long) begin
      dvd = {rd_hi_data, rd_lo_data};
    end else if (div_signed) begin
      dvd = {{16{rd_lo_data[15]}}, rd_lo_data};
    end else begin
      dvd = {16'h0000, rd_lo_data};
    end
    dvd_mag = (div_signed && dvd[31]) ? 32'(-dvd) : dvd;
    shl_rem = {div_rem[15:0], div_q[15]};
    trial   = {1'b0, shl_rem} - {2'b00, div_dsr};
  end

  assign div_busy = (div_state == DIV_RUN);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_state <= DIV_IDLE;
      div_cnt   <= 5'h00;
      div_rem   <= 17'h0_0000;
      div_q     <= 16'h0000;
      div_dsr   <= 16'h0000;
      neg_q     <= 1'b0;
      neg_r     <= 1'b0;
    end else if (div_step) begin
      case (div_state)
        DIV_IDLE: begin
          div_rem   <= {1'b0, dvd_mag[31:16]};
          div_q     <= dvd_mag[15:0];
          div_dsr   <= (div_signed && rd_dsr_data[15]) ?
                       16'(-rd_dsr_data) : rd_dsr_data;
          neg_q     <= div_signed && (dvd[31] ^ rd_dsr_data[15]);
          neg_r     <= div_signed && dvd[31];
          div_cnt   <= 5'h00;
          div_state <= DIV_RUN;
        end
        DIV_RUN: begin
          if (div_cnt != DIV_BITS) begin
            if (!trial[17]) begin
              div_rem <= trial[16:0];
              div_q   <= {div_q[14:0], 1'b1};
            end else begin
              div_rem <= shl_rem;
              div_q   <= {div_q[14:0], 1'b0};
            end
            div_cnt <= div_cnt + 5'h01;
          end else begin
            div_state <= DIV_IDLE;
          end
        end
        default: div_state <= DIV_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wreg0_we   <= 1'b0;
      wreg1_we   <= 1'b0;
      wreg0_data <= 16'h0000;
      wreg1_data <= 16'h0000;
    end else begin
      wreg0_we <= 1'b0;
      wreg1_we <= 1'b0;
      if (div_step && div_busy && (div_cnt == DIV_BITS)) begin
        wreg0_we   <= 1'b1;
        wreg1_we   <= 1'b1;
        wreg0_data <= neg_q ? 16'(-div_q) : div_q;
        wreg1_data <= neg_r ? 16'(-div_rem[15:0]) : div_rem[15:0];
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_dest;
    op_valid && !dst_to_mem |=> reg_we && !mem_we;
  endproperty
  a_dest: assert property (p_dest)
    else $error("register write not issued");

  property p_zero;
    op_valid && (op_code == OP_ADD) && !byte_mode &&
      (16'(opa + opb) == 16'h0000) |=> status_word[SW_Z];
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag not set");

  property p_borrow;
    op_valid && is_sub && !byte_mode |=>
      status_word[SW_C] == ($past(opa) >= $past(opb));
  endproperty
  a_borrow: assert property (p_borrow)
    else $error("borrow flag wrong");

  property p_dc_word;
    op_valid && (op_code == OP_ADD) && !byte_mode |=>
      status_word[SW_DC] ==
      ((9'($past(opa[7:0])) + 9'($past(opb[7:0]))) > 9'h0FF);
  endproperty
  a_dc_word: assert property (p_dc_word)
    else $error("half carry wrong");

  property p_wrap;
    op_valid && (op_code == OP_ADD) && !byte_mode &&
      !opa[15] && !opb[15] && sum17[15] |=> status_word[SW_OV];
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("signed wrap not flagged");

  property p_byte_n;
    op_valid && (op_code == OP_ADD) && byte_mode |=>
      status_word[SW_N] == (($past(opa[7:0]) + $past(opb[7:0])) >= 8'h80);
  endproperty
  a_byte_n: assert property (p_byte_n)
    else $error("byte negative flag wrong");

  property p_mul_uu;
    op_valid && (op_code == OP_MUL) && (mul_mode == MUL_UU) |=>
      {res_hi, res_data} == ({16'h0000, $past(opa)} * {16'h0000, $past(opb)});
  endproperty
  a_mul_uu: assert property (p_mul_uu)
    else $error("unsigned product wrong");

  property p_shift_zero;
    op_valid && (op_code == OP_SHL) && (shift_amt == 6'sd0) &&
      !byte_mode |=> res_data == $past(opa);
  endproperty
  a_shift_zero: assert property (p_shift_zero)
    else $error("zero shift changed operand");

  property p_shift_dir;
    op_valid && (op_code == OP_SHL) && !byte_mode &&
      (shift_amt == 6'sd1) |=> res_data == {1'b0, $past(opa[15:1])};
  endproperty
  a_shift_dir: assert property (p_shift_dir)
    else $error("positive shift not rightward");

  property p_div_end;
    div_step && div_busy && (div_cnt == DIV_BITS) |=>
      wreg0_we && wreg1_we && !div_busy;
  endproperty
  a_div_end: assert property (p_div_end)
    else $error("divide did not finish after last bit");

  property p_div_hold;
    div_busy && !div_step |=> $stable(div_cnt) && $stable(div_q) &&
      !wreg0_we;
  endproperty
  a_div_hold: assert property (p_div_hold)
    else $error("divide state moved without a step");

  c_add_ov: cover property (op_valid && (op_code == OP_ADD) &&
    f_ov);
  c_mul: cover property (op_valid && (op_code == OP_MUL));
  c_shl_left: cover property (op_valid && (op_code == OP_SHL) &&
    shift_amt[5]);
  c_div_done: cover property (wreg0_we);

endmodule // calu_core

// *** dv/calu_regs_model.sv ***
// Register array model behind the datapath's divide ports.
// Assumes the bench preloads registers and issues divide steps.
`timescale 1ns/1ps
module calu_regs_model (
  input  wire logic        clk,          // Instruction clock
  input  wire logic        ld_we,        // Preload strobe
  input  wire logic [3:0]  ld_addr,      // Preload index
  input  wire logic [15:0] ld_data,      // Preload value
  input  wire logic [3:0]  rd_dsr_addr,  // Divisor index
  input  wire logic [3:0]  rd_lo_addr,   // Dividend low index
  input  wire logic [3:0]  rd_hi_addr,   // Dividend high index
  input  wire logic        wreg0_we,     // Quotient write
  input  wire logic [15:0] wreg0_data,   // Quotient
  input  wire logic        wreg1_we,     // Remainder write
  input  wire logic [15:0] wreg1_data,   // Remainder
  output logic      [15:0] rd_dsr_data,  // Divisor data
  output logic      [15:0] rd_lo_data,   // Dividend low data
  output logic      [15:0] rd_hi_data,   // Dividend high data
  output logic      [15:0] w0,           // Register zero
  output logic      [15:0] w1            // Register one
);
  logic [15:0] regs [16];

  always_ff @(posedge clk) begin
    if (ld_we) begin
      regs[ld_addr] <= ld_data;
    end
    if (wreg0_we) begin
      regs[0] <= wreg0_data;
    end
    if (wreg1_we) begin
      regs[1] <= wreg1_data;
    end
  end

  // Reads are live, so a late latch in the divider shows as bad data
  assign rd_dsr_data = regs[rd_dsr_addr];
  assign rd_lo_data  = regs[rd_lo_addr];
  assign rd_hi_data  = regs[rd_hi_addr];
  assign w0          = regs[0];
  assign w1          = regs[1];
endmodule // calu_regs_model

// *** dv/testbench.sv ***
// Self-checking bench for the arithmetic datapath and divider.
// Assumes one 200 MHz clock; inputs change by NBA at rising edges.
`timescale 1ns/1ps
module testbench;
  import calu_pkg::*;
  typedef struct {
    logic [15:0] r, h, sw;
    logic        mul, dst;
  } calu_exp_t;
  logic              clk, rstn, op_valid, byte_mode, dst_to_mem;
  logic              a_from_mem, b_from_mem, reg_we, mem_we, exp_we;
  calu_op_t          op_code;
  calu_mul_t         mul_mode;
  logic [15:0]       reg_a, mem_a, reg_b, mem_b, res_data, res_hi;
  logic [15:0]       status_word, exp_sw, ld_data, w0, w1;
  logic [15:0]       rd_dsr_data, rd_lo_data, rd_hi_data;
  logic [15:0]       wreg0_data, wreg1_data;
  logic [4:0]        mul_lit;
  logic signed [5:0] shift_amt;
  logic              div_step, div_signed, div_long, div_busy;
  logic              wreg0_we, wreg1_we, ld_we;
  logic [3:0]        divisor_reg, dividend_low_reg, ld_addr;
  logic [3:0]        rd_dsr_addr, rd_lo_addr, rd_hi_addr;
  int                err_count, comparisons, cycles;
  calu_exp_t         expq [$];
  calu_exp_t         mon_e;
  logic signed [5:0] amts [6] = '{6'sd1, 6'sd16, -6'sd16, 6'sd0,
                                  -6'sd3, 6'sd5};

  calu_core calu_core_i (.clk, .rstn, .op_valid, .op_code, .byte_mode,
    .a_from_mem, .b_from_mem, .reg_a, .mem_a, .reg_b, .mem_b, .mul_lit,
    .mul_mode, .shift_amt, .dst_to_mem, .res_data, .res_hi, .reg_we,
    .mem_we, .status_word, .div_step, .div_signed, .div_long,
    .divisor_reg, .dividend_low_reg, .rd_dsr_addr, .rd_lo_addr,
    .rd_hi_addr, .rd_dsr_data, .rd_lo_data, .rd_hi_data, .div_busy,
    .wreg0_we, .wreg0_data, .wreg1_we, .wreg1_data);
  calu_regs_model calu_regs_model_i (.clk, .ld_we, .ld_addr, .ld_data,
    .rd_dsr_addr, .rd_lo_addr, .rd_hi_addr, .wreg0_we, .wreg0_data,
    .wreg1_we, .wreg1_data, .rd_dsr_data, .rd_lo_data, .rd_hi_data,
    .w0, .w1);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("Counts: %0d compared, %0d mismatched", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  function automatic longint sx(logic [15:0] v, logic sg);
    return sg ? longint'($signed(v)) : longint'(v);
  endfunction

  // Issue one op at a rising edge; the monitor checks it a cycle later
  task automatic alu(calu_op_t op, logic bm, logic [15:0] a, b,
                     logic [4:0] lit, calu_mul_t mm,
                     logic signed [5:0] sh, logic mem);
    calu_exp_t   e;
    logic [15:0] bx, w, r;
    logic [16:0] t, hh;
    longint      x, y;
    int          mb;
    e.sw = exp_sw;
    e.mul = (op == OP_MUL);
    e.dst = mem;
    e.h = 16'h0000;
    mb = bm ? 7 : 15;
    w = bm ? 16'h00FF : 16'hFFFF;
    bx = (op == OP_SUB) ? ~b : b;
    t = {1'b0, a & w} + {1'b0, bx & w} + 17'(op == OP_SUB);
    hh = {1'b0, a & (w >> (bm ? 4 : 8))} + {1'b0, bx & (w >> (bm ? 4 : 8))}
         + 17'(op == OP_SUB);
    case (op)
      OP_ADD, OP_SUB: r = t[15:0];
      OP_AND:         r = a & b;
      OP_IOR:         r = a | b;
      OP_XOR:         r = a ^ b;
      OP_MUL: begin
        x = sx(a, mm inside {MUL_SS, MUL_SU, MUL_SL});
        y = (mm inside {MUL_SL, MUL_UL}) ? longint'(lit) :
            sx(b, mm inside {MUL_SS, MUL_US});
        if (mm == MUL_BB) begin
          x = longint'(a[7:0]);
          y = longint'(b[7:0]);
        end
        x = x * y;
        r = x[15:0];
        e.h = x[31:16];
      end
      default: begin
        x = sx(a, op == OP_SHA);
        x = (sh > 0) ? (x >>> sh) : (x <<< (-sh));
        r = x[15:0];
      end
    endcase
    e.r = bm ? {a[15:8], r[7:0]} : r;
    if (op != OP_MUL) begin
      e.sw[SW_N] = r[mb];
      e.sw[SW_Z] = ((r & w) == 16'h0000);
    end
    if (op inside {OP_ADD, OP_SUB}) begin
      e.sw[SW_C]  = t[mb + 1];
      e.sw[SW_DC] = hh[(mb + 1) / 2];
      e.sw[SW_OV] = (a[mb] == bx[mb]) && (t[mb] != a[mb]);
    end
    op_valid <= 1'b1;
    op_code <= op;
    byte_mode <= bm;
    a_from_mem <= mem;
    b_from_mem <= mem;
    dst_to_mem <= mem;
    reg_a <= mem ? ~a : a;
    mem_a <= mem ? a : ~a;
    reg_b <= mem ? ~b : b;
    mem_b <= mem ? b : ~b;
    mul_lit <= lit;
    mul_mode <= mm;
    shift_amt <= sh;
    expq.push_back(e);
    exp_sw = e.sw;
    @(posedge clk);
  endtask

  always @(posedge clk) exp_we <= op_valid & rstn;

  always @(negedge clk) begin
    if (rstn === 1'b1 && exp_we === 1'b1) begin
      mon_e = expq.pop_front();
      chk({reg_we, mem_we, res_data}, {!mon_e.dst, mon_e.dst, mon_e.r});
      chk(status_word, mon_e.sw);
      if (mon_e.mul) chk(res_hi, mon_e.h);
    end else if (rstn === 1'b1) begin
      chk({reg_we, mem_we}, 32'h0000_0000);
    end
  end

  task automatic load(logic [3:0] ad, logic [15:0] d);
    ld_we <= 1'b1;
    ld_addr <= ad;
    ld_data <= d;
    @(posedge clk);
  endtask

  // Divisor select, sign and size modes change after the first step to prove they are held
  task automatic div(logic sg, lg, logic [3:0] dr, lr,
                     logic [31:0] dd, logic [15:0] dv, int gap);
    longint x, y, q, r;
    x = lg ? (sg ? longint'($signed(dd)) : longint'(dd)) : sx(dd[15:0], sg);
    y = sx(dv, sg);
    q = x / y;
    r = x % y;
    load({lr[3:1], 1'b0}, dd[15:0]);
    load({lr[3:1], 1'b1}, dd[31:16]);
    load(dr, dv);
    ld_we <= 1'b0;
    divisor_reg <= dr;
    dividend_low_reg <= lr;
    div_signed <= sg;
    div_long <= lg;
    @(negedge clk);
    chk({rd_dsr_addr, rd_lo_addr, rd_hi_addr}, {dr, lr[3:1], 1'b0, lr[3:1], 1'b1});
    @(posedge clk);
    for (int i = 0; i < 18; i++) begin
      div_step <= 1'b1;
      @(posedge clk);
      if (i == 0) begin
        div_signed <= ~sg;
        div_long <= ~lg;
        divisor_reg <= dr + 4'h1;
      end
      if (i == gap) begin
        div_step <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({div_busy, wreg0_we}, 32'h0000_0002);
        @(posedge clk);
      end
    end
    div_step <= 1'b0;
    @(negedge clk);
    chk({wreg0_we, wreg1_we, div_busy}, 32'h0000_0006);
    chk({wreg0_data, wreg1_data}, {q[15:0], r[15:0]});
    @(negedge clk);
    chk({w0, w1}, {q[15:0], r[15:0]});
    chk(32'(wreg0_we), 32'h0000_0000);
    @(posedge clk);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      test_done;
    end
  end

  initial begin
    {rstn, op_valid, byte_mode, a_from_mem, b_from_mem, dst_to_mem} = 0;
    {reg_a, mem_a, reg_b, mem_b, mul_lit, shift_amt} = 0;
    {div_step, div_signed, div_long, divisor_reg, dividend_low_reg} = 0;
    {ld_we, ld_addr, ld_data, exp_sw} = 0;
    op_code = OP_ADD;
    mul_mode = MUL_SS;
    repeat (10) @(posedge clk);
    chk({status_word, reg_we, div_busy}, 32'h0000_0000);
    rstn <= 1'b1;
    @(posedge clk);
    alu(OP_ADD, 0, 16'h7FFF, 16'h0001, 0, MUL_SS, 0, 0);
    alu(OP_ADD, 0, 16'hFFFF, 16'h0001, 0, MUL_SS, 0, 1);
    alu(OP_SUB, 0, 16'h0005, 16'h0007, 0, MUL_SS, 0, 0);
    alu(OP_SUB, 0, 16'h8000, 16'h0001, 0, MUL_SS, 0, 1);
    alu(OP_ADD, 1, 16'h12F8, 16'h3409, 0, MUL_SS, 0, 0);
    alu(OP_SUB, 1, 16'hAB10, 16'h0020, 0, MUL_SS, 0, 1);
    alu(OP_SUB, 1, 16'h0080, 16'h0001, 0, MUL_SS, 0, 0);
    for (int k = 0; k < 6; k++) begin
      alu(calu_op_t'(2 + k % 3), k[0], 16'hF0F1, 16'h0FF1, 0, MUL_SS, 0, k[1]);
    end
    for (int m = 0; m < 7; m++) begin
      alu(OP_MUL, 0, 16'hFFFE, 16'h8003, 5'h1F, calu_mul_t'(m), 0, m[0]);
    end
    for (int k = 0; k < 12; k++) begin
      alu(k < 6 ? OP_SHL : OP_SHA, k[2], 16'h9C31, 16'h0000, 0, MUL_SS, amts[k % 6], k[0]);
    end
    op_valid <= 1'b0;
    div(0, 1, 4'h5, 4'h2, 32'h0012_3456, 16'h0100, 5);
    div_step <= 1'b1;
    repeat (4) @(posedge clk);
    div_step <= 1'b0;
    rstn <= 1'b0;
    @(negedge clk);
    chk({div_busy, reg_we, wreg0_we, status_word}, 32'h0000_0000);
    @(posedge clk);
    rstn <= 1'b1;
    exp_sw = 16'h0000;
    div(1, 1, 4'h3, 4'h7, 32'hFFFE_7960, 16'h0007, -1);
    div(0, 0, 4'h9, 4'h4, 32'h5A5A_FFFF, 16'h0003, 16);
    div(1, 0, 4'hF, 4'hC, 32'h0000_FFF9, 16'h0002, 0);
    alu(OP_ADD, 0, 16'h0001, 16'h0001, 0, MUL_SS, 0, 0);
    op_valid <= 1'b0;
    repeat (3) @(posedge clk);
    test_done;
  end
endmodule // testbench
